// *** safing_pkg.sv ***
// Package for the safing serial command logic
package safing_pkg;
    localparam logic [7:0] OP_CTRL_WR   = 8'h58;
    localparam logic [7:0] OP_CTRL_RD   = 8'h98;
    localparam logic [7:0] OP_SEED_WR   = 8'h59;
    localparam logic [7:0] OP_SEED_RD   = 8'h99;
    localparam logic [7:0] OP_KEY_WR    = 8'h5A;
    localparam logic [7:0] OP_KEY_RD    = 8'h9A;
    localparam logic [7:0] OP_UNLOCK_WR = 8'h4D;
    localparam logic [7:0] OP_UNLOCK_RD = 8'h8D;
    localparam logic [7:0] OP_TH_WR_LO  = 8'h45;
    localparam logic [7:0] OP_TH_WR_HI  = 8'h4C;
    // Key derivation and threshold unlock mask
    localparam logic [7:0] KEY_XOR      = 8'hA5;
    localparam logic [7:0] UNLOCK_XOR   = 8'hAD;
    // Response header fields
    localparam logic [2:0] HDR_WR       = 3'h1;
    localparam logic [2:0] HDR_RD       = 3'h2;
    localparam logic [2:0] HDR_ERR      = 3'h0;
    localparam logic [3:0] RSP_TAG      = 4'hE;
    localparam logic [7:0] ERR_DATA     = 8'h02;
    // Field positions in the command word
    localparam int MR_LSB  = 2;
    localparam int TEN_BIT = 1;
    localparam int LEV_BIT = 0;
    localparam int OE_BIT  = 1;
    localparam int SE_BIT  = 0;
    // Reset values
    localparam logic [1:0] MR_RESET  = 2'h0;
    localparam logic [7:0] SEED_RESET = 8'h01;
    // Arming keep-alive: key write must come within this time
    localparam int KEEP_ALIVE_US  = 100;
    localparam int CLK_MHZ        = 250;
    localparam int KEEP_ALIVE_CYC = KEEP_ALIVE_US * CLK_MHZ;
    localparam int FRAME_BITS     = 16;

    typedef enum logic [1:0] {
        MODE_STARTUP,
        MODE_SAFING,
        MODE_SCRAP,
        MODE_ARMING
    } mode_e;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] data;
    } frame_s;

    typedef struct packed {
        logic [2:0] hdr;
        logic       par;
        logic [3:0] tag;
        logic [7:0] data;
    } resp_s;
endpackage : safing_pkg

// *** safing_spi_command_logic.sv ***
// Serial command interpreter for the safing state machine
`timescale 1ns/100ps
module safing_spi_command_logic
    import safing_pkg::*;
#(
    parameter int KEEP_ALIVE = KEEP_ALIVE_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    input  wire logic       sync_pulse_i,
    input  wire logic       seq_fault_i,
    input  wire logic       offset_detect_i,
    input  wire logic       sensor_valid_i,
    input  wire logic [7:0] sensor_sample_i,
    input  wire logic       diag_mode_i,
    output logic [7:0]      analog_result_reg_o,
    output logic [1:0]      mode_state_field_o,
    output logic            arm_out_o,
    output logic            fire_inhibit_out_o,
    output logic            arm_test_active_o,
    output logic            thresh_write_ok_o,
    output logic [7:0]      thresh_data_o
);
    // ---------------- Link domain (sclk) ----------------
    // Mode 0 style: sample mosi on rising sclk, shift miso on falling.
    logic [15:0] rx_shift;
    logic [3:0]  rx_cnt;
    logic [15:0] rx_word;
    logic        rx_toggle;
    logic [15:0] tx_shift;
    logic [3:0]  tx_cnt;
    // Written in the system domain once per frame, read here (see below)
    logic [15:0] resp_word;

    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_shift  <= 16'h0000;
            rx_cnt    <= 4'h0;
            rx_word   <= 16'h0000;
            rx_toggle <= 1'b0;
        end else if (!cs_n_i) begin
            rx_shift <= {rx_shift[14:0], mosi_i};
            rx_cnt   <= rx_cnt + 4'h1;
            if (rx_cnt == 4'hF) begin
                rx_word   <= {rx_shift[14:0], mosi_i};
                rx_toggle <= ~rx_toggle;
            end
        end
    end

    // The response word is loaded a few system clocks after a frame ends and
    // then held until the next frame has ended, so this side reads it as a
    // static word. No extra link clocks are needed between frames; the cost
    // is that frames must be spaced by the minimum idle gap.
    always_ff @(negedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_shift <= 16'h0000;
            tx_cnt   <= 4'h0;
        end else if (!cs_n_i) begin
            tx_cnt   <= tx_cnt + 4'h1;
            tx_shift <= (tx_cnt == 4'h0) ? {resp_word[14:0], 1'b0}
                                         : {tx_shift[14:0], 1'b0};
        end
    end
    // Bit 15 goes out before the first falling edge, from the held word
    wire logic tx_bit = (tx_cnt == 4'h0) ? resp_word[15] : tx_shift[15];
    assign miso_o    = tx_bit;
    assign miso_oe_o = ~cs_n_i;

    // ---------------- System domain ----------------
    logic [2:0]  tog_sync;
    logic [15:0] rx_hold;
    logic [1:0]  sync_s;
    logic        sync_d;
    logic [1:0]  seq_s;
    logic [1:0]  off_s;
    logic        frame_new;
    logic        resp_load;
    logic        unl_ok_q;
    mode_e       mode;
    logic        test_en;
    logic        test_lev;
    logic        seq_flag;
    logic        off_flag;
    logic [3:0]  valid_cnt;
    logic [7:0]  seed_cnt;
    logic [7:0]  seed_frozen;
    logic [7:0]  key_calc;
    logic [7:0]  unlock_key;
    logic        prev_unlock;
    logic [31:0] alive_cnt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tog_sync <= 3'h0;
            sync_s   <= 2'h0;
            sync_d   <= 1'b0;
            seq_s    <= 2'h0;
            off_s    <= 2'h0;
            rx_hold  <= 16'h0000;
            frame_new <= 1'b0;
            resp_load <= 1'b0;
        end else begin
            tog_sync <= {tog_sync[1:0], rx_toggle};
            sync_s   <= {sync_s[0], sync_pulse_i};
            sync_d   <= sync_s[1];
            seq_s    <= {seq_s[0], seq_fault_i};
            off_s    <= {off_s[0], offset_detect_i};
            // Word is stable for a frame after the toggle, safe to take
            if (tog_sync[2] != tog_sync[1])
                rx_hold <= rx_word;
            // Decode runs on the held copy, the answer is loaded a cycle
            // later once mode and key have taken the new frame
            frame_new <= (tog_sync[2] != tog_sync[1]);
            resp_load <= frame_new;
        end
    end

    frame_s cmd;
    assign cmd = rx_hold;
    wire logic is_ctrl_wr = frame_new && cmd.op == OP_CTRL_WR;
    wire logic is_seed_rd = frame_new && cmd.op == OP_SEED_RD;
    wire logic is_key_wr  = frame_new && cmd.op == OP_KEY_WR;
    wire logic is_unl_wr  = frame_new && cmd.op == OP_UNLOCK_WR;
    // Status access acts when its answer is loaded, not at decode
    wire logic ctrl_op    = cmd.op == OP_CTRL_RD
                            || cmd.op == OP_CTRL_WR;
    wire logic ctrl_access = resp_load && ctrl_op;
    wire logic is_th_wr   = frame_new && cmd.op >= OP_TH_WR_LO
                            && cmd.op <= OP_TH_WR_HI;
    wire logic [1:0] mr   = cmd.data[MR_LSB +: 2];
    wire logic in_startup = (mode == MODE_STARTUP);
    wire logic key_ok     = (cmd.data == key_calc);
    wire logic th_ok      = prev_unlock && in_startup
                            && (unlock_key == (cmd.data ^ UNLOCK_XOR));
    wire logic sync_rise  = sync_s[1] & ~sync_d;
    // Diagnostic mode exists only inside start-up, so the test needs both
    wire logic test_on    = test_en && diag_mode_i && in_startup;

    // Keep-alive restarts on every matching key; a control write in arming
    // holds the count for that one cycle, or leaves arming when its mode field is 1 or 2
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode        <= MODE_STARTUP;
            test_en     <= 1'b0;
            test_lev    <= 1'b0;
            alive_cnt   <= 32'h0;
        end else begin
            if (is_ctrl_wr) begin
                test_en  <= cmd.data[TEN_BIT];
                test_lev <= cmd.data[LEV_BIT];
                if (mr == 2'h1)
                    mode <= MODE_SAFING;
                else if (mr == 2'h2)
                    mode <= MODE_SCRAP;
            end else if (is_key_wr && key_ok) begin
                mode      <= MODE_ARMING;
                alive_cnt <= 32'h0;
            end else if (mode == MODE_ARMING) begin
                if (alive_cnt >= KEEP_ALIVE - 1)
                    mode <= MODE_SAFING;
                else
                    alive_cnt <= alive_cnt + 32'h1;
            end
        end
    end

    // Flags: a set in the same cycle as a clear wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_flag  <= 1'b0;
            off_flag  <= 1'b0;
            valid_cnt <= 4'h0;
            analog_result_reg_o <= 8'h00;
        end else begin
            if (seq_s[1])
                seq_flag <= 1'b1;
            else if (sync_rise)
                seq_flag <= 1'b0;
            // Cleared as the answer is loaded, so that read still shows it
            if (off_s[1])
                off_flag <= 1'b1;
            else if (ctrl_access)
                off_flag <= 1'b0;
            if (sensor_valid_i)
                valid_cnt <= valid_cnt + 4'h1;
            if (sensor_valid_i && !off_flag)
                analog_result_reg_o <= sensor_sample_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seed_cnt    <= SEED_RESET;
            seed_frozen <= SEED_RESET;
            key_calc    <= SEED_RESET ^ KEY_XOR;
            unlock_key  <= 8'h00;
            prev_unlock <= 1'b0;
            thresh_write_ok_o <= 1'b0;
            thresh_data_o     <= 8'h00;
        end else begin
            // Counter keeps running; only the copy taken by a seed read is
            // frozen, so the key stays tied to the seed that was handed out
            seed_cnt <= seed_cnt + 8'h01;
            if (is_seed_rd) begin
                seed_frozen <= seed_cnt;
                key_calc    <= seed_cnt ^ KEY_XOR;
            end
            if (is_unl_wr && in_startup)
                unlock_key <= cmd.data;
            if (frame_new)
                prev_unlock <= is_unl_wr && in_startup;
            // One-cycle strobe per accepted threshold frame
            thresh_write_ok_o <= is_th_wr && th_ok;
            if (is_th_wr && th_ok)
                thresh_data_o <= cmd.data;
        end
    end

    // Response to the frame just received, sent in the next frame
    resp_s rsp;
    logic  rsp_err;
    always_comb begin
        rsp_err  = 1'b0;
        rsp.hdr  = HDR_WR;
        rsp.tag  = RSP_TAG;
        rsp.data = 8'h00;
        rsp.par  = 1'b0;
        if (cmd.op == OP_CTRL_RD || cmd.op == OP_CTRL_WR) begin
            rsp.hdr = (cmd.op == OP_CTRL_RD) ? HDR_RD : HDR_WR;
            rsp.data = {valid_cnt, mode, off_flag, seq_flag};
        end else if (cmd.op == OP_SEED_RD) begin
            rsp.hdr  = HDR_RD;
            rsp.data = seed_frozen;
        end else if (cmd.op == OP_SEED_WR || cmd.op == OP_KEY_RD
                     || cmd.op == OP_UNLOCK_RD) begin
            rsp_err = 1'b1;
        end else if (cmd.op == OP_UNLOCK_WR) begin
            rsp_err = !unl_ok_q;
        end
        // Error answer overrides any data chosen above
        if (rsp_err) begin
            rsp.hdr  = HDR_ERR;
            rsp.data = ERR_DATA;
        end
        rsp.par = ^{rsp.hdr, rsp.tag, rsp.data};
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unl_ok_q  <= 1'b1;
            resp_word <= 16'h0000;
        end else begin
            if (is_unl_wr)
                unl_ok_q <= in_startup;
            if (resp_load)
                resp_word <= rsp;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arm_out_o          <= 1'b0;
            fire_inhibit_out_o <= 1'b0;
            arm_test_active_o  <= 1'b0;
            mode_state_field_o <= 2'h0;
        end else begin
            arm_test_active_o  <= test_on;
            mode_state_field_o <= mode;
            if (test_on) begin
                arm_out_o          <= test_lev;
                fire_inhibit_out_o <= test_lev;
            end else begin
                arm_out_o          <= (mode == MODE_ARMING);
                fire_inhibit_out_o <= (mode != MODE_ARMING);
            end
        end
    end
endmodule : safing_spi_command_logic

// *** safing_chk.sv ***
// Assertions for the safing serial command logic
`timescale 1ns/100ps
module safing_chk
    import safing_pkg::*;
#(
    parameter int KEEP_ALIVE = KEEP_ALIVE_CYC
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       cs_n_i,
    input wire logic       sensor_valid_i,
    input wire logic       miso_oe_o,
    input wire logic [7:0] analog_result_reg_o,
    input wire logic [1:0] mode_state_field_o,
    input wire logic       arm_out_o,
    input wire logic       fire_inhibit_out_o,
    input wire logic       arm_test_active_o,
    input wire logic       thresh_write_ok_o
);
    // Cycles since the last frame ended; saturates so it never wraps
    logic [15:0] idle_cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) idle_cnt <= '0;
        else if (!cs_n_i) idle_cnt <= '0;
        else if (idle_cnt != 16'hFFFF) idle_cnt <= idle_cnt + 16'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_test; arm_test_active_o [*3]; endsequence
    sequence s_quiet; !arm_test_active_o [*3]; endsequence
    chk_oe_select: assert property (miso_oe_o == !cs_n_i)
        else $error("miso enable does not follow select");
    chk_test_level: assert property (s_test |-> arm_out_o == fire_inhibit_out_o)
        else $error("test outputs differ");
    chk_test_diag: assert property (arm_test_active_o |-> mode_state_field_o == 2'h0)
        else $error("output test outside diagnostic mode");
    chk_normal_out: assert property (s_quiet |-> fire_inhibit_out_o != arm_out_o)
        else $error("arming outputs not complementary");
    chk_arm_expiry: assert property (idle_cnt > KEEP_ALIVE + 16 |-> mode_state_field_o != 2'h3)
        else $error("arming kept without key writes");
    chk_mode_hold: assert property ((idle_cnt > 16'd8 && $past(mode_state_field_o) != 2'h3)
        |-> $stable(mode_state_field_o))
        else $error("mode changed without a frame");
    chk_result_cause: assert property ($changed(analog_result_reg_o)
        |-> $past(sensor_valid_i) || $past(sensor_valid_i, 2))
        else $error("result changed without a sensor message");
    chk_thr_pulse: assert property (thresh_write_ok_o
        |-> (mode_state_field_o == 2'h0) ##1 !thresh_write_ok_o)
        else $error("threshold write outside start-up or too long");
    chk_thr_timing: assert property (thresh_write_ok_o |-> idle_cnt < 16'd12)
        else $error("threshold write not tied to a frame");
endmodule : safing_chk

bind safing_spi_command_logic safing_chk #(.KEEP_ALIVE(KEEP_ALIVE)) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .sensor_valid_i(sensor_valid_i), .miso_oe_o(miso_oe_o),
    .analog_result_reg_o(analog_result_reg_o),
    .mode_state_field_o(mode_state_field_o), .arm_out_o(arm_out_o),
    .fire_inhibit_out_o(fire_inhibit_out_o),
    .arm_test_active_o(arm_test_active_o),
    .thresh_write_ok_o(thresh_write_ok_o));

// *** spi_host_model.sv ***
// Serial master model standing in for the system microcontroller
`timescale 1ns/100ps
module spi_host_model
    import safing_pkg::*;
(
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input wire logic  miso_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input frame_s tx, output resp_s rx);
        logic [15:0] v;
        logic [15:0] w;
        v = tx;
        cs_n_o = 1'b0;
        mosi_o = v[15];
        #6;
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b1;
            w[i] = miso_i;
            #6;
            sclk_o = 1'b0;
            if (i > 0) mosi_o = v[i-1];
            #6;
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        // Clock stays idle between frames; the gap lets the answer load
        #40;
        rx = w;
        #20;
    endtask : xfer
endmodule : spi_host_model

// *** safing_spi_command_logic_tb.sv ***
// Self-checking bench for the safing serial command logic
`timescale 1ns/100ps
module safing_spi_command_logic_tb
    import safing_pkg::*;
;
    localparam int KA = 200;
    logic clk_i = 1'b0, rst_n_i = 1'b0, sync_pulse_i = 1'b0;
    logic seq_fault_i = 1'b0, offset_detect_i = 1'b0, diag_mode_i = 1'b0;
    logic sensor_valid_i = 1'b0, thr_seen = 1'b0;
    logic [7:0] sensor_sample_i = 8'h00;
    wire logic sclk_i, cs_n_i, mosi_i;
    logic miso_o, miso_oe_o, arm_out_o, fire_inhibit_out_o;
    logic arm_test_active_o, thresh_write_ok_o;
    logic [7:0] analog_result_reg_o, thresh_data_o, s;
    logic [1:0] mode_state_field_o;
    int err_total = 0, checks = 0;
    resp_s r;

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (thresh_write_ok_o === 1'b1) thr_seen <= 1'b1;

    safing_spi_command_logic #(.KEEP_ALIVE(KA)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
        .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .sync_pulse_i(sync_pulse_i), .seq_fault_i(seq_fault_i),
        .offset_detect_i(offset_detect_i), .sensor_valid_i(sensor_valid_i),
        .sensor_sample_i(sensor_sample_i), .diag_mode_i(diag_mode_i),
        .analog_result_reg_o(analog_result_reg_o),
        .mode_state_field_o(mode_state_field_o), .arm_out_o(arm_out_o),
        .fire_inhibit_out_o(fire_inhibit_out_o),
        .arm_test_active_o(arm_test_active_o),
        .thresh_write_ok_o(thresh_write_ok_o), .thresh_data_o(thresh_data_o));
    spi_host_model i_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i),
        .miso_i(miso_o));

    task automatic cmp_rsp(input resp_s got, input resp_s exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rsp
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val
    function automatic resp_s mk(input logic [2:0] h, input logic [7:0] d);
        return '{h, ^{h, RSP_TAG, d}, RSP_TAG, d};
    endfunction : mk
    function automatic logic [7:0] outs();
        return {3'h0, arm_test_active_o, mode_state_field_o, arm_out_o,
                fire_inhibit_out_o};
    endfunction : outs
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic one(input logic [7:0] op, input logic [7:0] d,
                       output resp_s rsp);
        i_host.xfer({op, d}, rsp);
        @(negedge clk_i);
    endtask : one
    // A frame's answer arrives in the following frame
    task automatic send(input logic [7:0] op, input logic [7:0] d,
                        output resp_s rsp);
        resp_s t;
        one(op, d, t);
        one(OP_CTRL_RD, 8'h00, rsp);
    endtask : send
    task automatic status(input logic [7:0] d);
        send(OP_CTRL_RD, 8'h00, r);
        cmp_rsp(r, mk(HDR_RD, d));
    endtask : status
    task automatic pulse_valid(input logic [7:0] v);
        sensor_sample_i = v;
        sensor_valid_i = 1'b1;
        cyc(1);
        sensor_valid_i = 1'b0;
        cyc(1);
    endtask : pulse_valid

    task automatic t_errors();
        send(OP_SEED_WR, 8'h00, r);
        cmp_rsp(r, mk(HDR_ERR, ERR_DATA));
        send(OP_KEY_RD, 8'h00, r);
        cmp_rsp(r, mk(HDR_ERR, ERR_DATA));
        send(OP_UNLOCK_WR, 8'h3C, r);
        cmp_rsp(r, mk(HDR_WR, 8'h00));
        thr_seen = 1'b0;
        one(OP_UNLOCK_WR, 8'h3C, r);
        one(OP_TH_WR_LO, 8'h3C ^ UNLOCK_XOR, r);
        cyc(8);
        cmp_val({7'h0, thr_seen}, 8'h01);
        cmp_val(thresh_data_o, 8'h3C ^ UNLOCK_XOR);
        thr_seen = 1'b0;
        one(OP_TH_WR_LO, 8'h3C ^ UNLOCK_XOR, r);
        one(OP_UNLOCK_WR, 8'h3C, r);
        one(OP_TH_WR_LO, 8'h3D ^ UNLOCK_XOR, r);
        cyc(8);
        cmp_val({7'h0, thr_seen}, 8'h00);
    endtask : t_errors

    task automatic t_armtest();
        diag_mode_i = 1'b1;
        send(OP_CTRL_WR, 8'h03, r);
        cmp_rsp(r, mk(HDR_WR, 8'h00));
        cmp_val(outs(), 8'h13);
        send(OP_CTRL_WR, 8'h0E, r);
        cmp_val(outs(), 8'h10);
        send(OP_CTRL_WR, 8'h00, r);
        cmp_val(outs(), 8'h01);
        diag_mode_i = 1'b0;
        send(OP_CTRL_WR, 8'h03, r);
        cmp_val(outs(), 8'h01);
        send(OP_CTRL_WR, 8'h00, r);
    endtask : t_armtest

    task automatic t_flags();
        pulse_valid(8'h11);
        pulse_valid(8'h22);
        pulse_valid(8'h33);
        cmp_val(analog_result_reg_o, 8'h33);
        status(8'h30);
        seq_fault_i = 1'b1;
        cyc(4);
        seq_fault_i = 1'b0;
        status(8'h31);
        sync_pulse_i = 1'b1;
        cyc(4);
        sync_pulse_i = 1'b0;
        cyc(4);
        status(8'h30);
        offset_detect_i = 1'b1;
        cyc(4);
        status(8'h32);
        pulse_valid(8'h44);
        cmp_val(analog_result_reg_o, 8'h33);
        status(8'h42);
        offset_detect_i = 1'b0;
        cyc(4);
        send(OP_CTRL_RD, 8'h00, r);
        cmp_rsp(r, mk(HDR_RD, 8'h42));
        status(8'h40);
    endtask : t_flags

    task automatic t_modes();
        send(OP_CTRL_WR, 8'h04, r);
        cmp_val(outs(), 8'h05);
        send(OP_UNLOCK_WR, 8'h3C, r);
        cmp_rsp(r, mk(HDR_ERR, ERR_DATA));
        send(OP_SEED_RD, 8'h00, r);
        cmp_rsp(r, mk(HDR_RD, r.data));
        one(OP_KEY_WR, r.data ^ KEY_XOR ^ 8'h01, r);
        cyc(8);
        cmp_val(outs(), 8'h05);
        send(OP_SEED_RD, 8'h00, r);
        s = r.data;
        one(OP_KEY_WR, s ^ KEY_XOR, r);
        cyc(8);
        cmp_val(outs(), 8'h0E);
        repeat (4) begin
            one(OP_KEY_WR, s ^ KEY_XOR, r);
            cmp_val(outs(), 8'h0E);
        end
        status(8'h4C);
        cyc(KA + 40);
        cmp_val(outs(), 8'h05);
        send(OP_CTRL_WR, 8'h08, r);
        cmp_val(outs(), 8'h09);
        status(8'h48);
    endtask : t_modes

    task automatic wrap_up();
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    initial begin
        cyc(16);
        rst_n_i = 1'b1;
        cyc(4);
        cmp_val(outs(), 8'h01);
        status(8'h00);
        t_errors();
        t_armtest();
        t_flags();
        t_modes();
        wrap_up();
    end
endmodule : safing_spi_command_logic_tb
